// ### core/urh_consts.svh
/*
 * Constants of the receive packet header writer: record layout, header
 * bit positions, register offsets, reset values and event bits.
 * Assumes it is included by bare name from files inside core/ and tb/.
 */
`ifndef URH_CONSTS_SVH
`define URH_CONSTS_SVH

// Record layout
`define URH_HDR_LEN      11'd8
`define URH_MAX_PAYLOAD  11'd1280
`define URH_OFF_STAT     3'd0
`define URH_OFF_PID      3'd1
`define URH_OFF_TADDR    3'd2
`define URH_OFF_RSVD     3'd3
`define URH_OFF_FRM_LO   3'd4
`define URH_OFF_FRM_HI   3'd5
`define URH_OFF_CNT_LO   3'd6
`define URH_OFF_CNT_HI   3'd7

// Bits of header byte 0
`define URH_BIT_BADTOG   5
`define URH_BIT_TOG      6
`define URH_BIT_CRC      7

// Register offsets
`define URH_REG_FADDR    8'h00
`define URH_REG_STATUS   8'h01
`define URH_REG_INT_EN   8'h02
`define URH_REG_INT_CLR  8'h03
`define URH_REG_PTR_LO   8'h04
`define URH_REG_PTR_HI   8'h05
`define URH_REG_MEM_DATA 8'h06
`define URH_REG_BASE_LO  8'h07
`define URH_REG_BASE_HI  8'h08
`define URH_REG_CNT_LO   8'h09
`define URH_REG_CNT_HI   8'h0a

// Reset values
`define URH_FADDR_RST    7'h00
`define URH_INT_EN_RST   4'h0

// Event bits of status, clear and enable registers
`define URH_EV_DONE      0
`define URH_EV_CRC       1
`define URH_EV_LONG      2
`define URH_EV_TOG       3

`endif

// ### core/urh_hdr_writer.sv
/*
 * Receive packet header writer: stores the payload of each addressed packet
 * after an eight-byte header in a shared buffer, then writes the header.
 * Assumes synchronous inputs on clk, one packet at a time from the serial
 * engine, and a byte-wide register port from the microcontroller.
 */
`timescale 1ns/1ps
`include "urh_consts.svh"

// How it works
// - Each record starts with an eight-byte header at offsets 0 to 7.
// - Payload bytes go in order from offset 8 to n plus 7.
// - Serial engine stage writes header bytes 0 to 5.
// - DMA stage, not serial stage, writes header bytes 6 and 7.
// - Byte count of 11 bits is payload plus eight, split over bytes 6 and 7.
// - Byte 0 bit 5 set when toggle equals the previous toggle.
// - Byte 0 bit 6 holds the toggle of this packet.
// - Byte 0 bit 7 set on CRC failure, else clear.
// - Bytes 4 and 5 hold frame count and extended frame count.
// - All endpoints share one record pool, no per-endpoint queues.
// - Payloads of 0 to 1280 bytes are accepted.
// - A record starts only when the token matches the function address.
module urh_hdr_writer import urh_pkg::*; #(
	parameter int AW = 12
) (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output      logic [7:0] reg_rdata,
	input  wire logic       rx_start,
	input  wire urh_tok_t   rx_tok,
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_byte,
	input  wire logic       rx_end,
	input  wire logic       rx_crc_bad,
	output      logic       irq
);

	////////////////////////////////////////////////////////////////////////
	// State

	urh_state_t    state_r;
	urh_tok_t      tok_r;
	logic [10:0]   cnt_r;
	logic [2:0]    idx_r;
	logic          crc_r;
	logic          badtog_r;
	logic          long_r;
	logic [15:0]   prev_tog_r;
	logic [AW-1:0] base_r;
	logic [AW-1:0] last_base_r;
	logic [10:0]   last_cnt_r;
	logic [6:0]    faddr_r;
	logic [3:0]    st_r;
	logic [3:0]    st_nxt;
	logic [3:0]    en_r;
	logic [AW-1:0] ptr_r;
	logic [AW-1:0] ptr_nxt;
	logic [7:0]    mem_q;
	logic          mem_we;
	logic [10:0]   mem_off;
	logic [7:0]    mem_wd;
	logic [AW-1:0] mem_wa;
	logic [10:0]   total;
	logic [3:0]    ev_set;
	logic [3:0]    ev_clr;
	logic          hit;
	logic          rec_end;

	assign total = cnt_r + `URH_HDR_LEN;
	assign hit = rx_start && (rx_tok.addr == faddr_r);
	assign rec_end = (state_r == URH_DMA) && (idx_r == `URH_OFF_CNT_HI);

	////////////////////////////////////////////////////////////////////////
	// Record sequencer

	// Walks idle, payload, serial header bytes, DMA header bytes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= URH_IDLE;
			idx_r   <= 3'd0;
		end else begin
			case (state_r)
				URH_IDLE: begin
					if (hit) begin
						state_r <= URH_PAY;
					end
				end
				URH_PAY: begin
					if (rx_end) begin
						state_r <= URH_SER;
						idx_r   <= `URH_OFF_STAT;
					end
				end
				URH_SER: begin
					idx_r <= idx_r + 3'd1;
					if (idx_r == `URH_OFF_FRM_HI) begin
						state_r <= URH_DMA;
					end
				end
				URH_DMA: begin
					idx_r <= idx_r + 3'd1;
					if (idx_r == `URH_OFF_CNT_HI) begin
						state_r <= URH_IDLE;
					end
				end
				default: state_r <= URH_IDLE;
			endcase
		end
	end

	// Packet context latched at the token and at the end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tok_r      <= '0;
			crc_r      <= 1'b0;
			badtog_r   <= 1'b0;
			prev_tog_r <= 16'h0000;
		end else begin
			if (state_r == URH_IDLE && hit) begin
				tok_r <= rx_tok;
			end
			if (state_r == URH_PAY && rx_end) begin
				crc_r <= rx_crc_bad;
				badtog_r <= (tok_r.toggle == prev_tog_r[tok_r.ep]);
				if (!rx_crc_bad) begin
					prev_tog_r[tok_r.ep] <= tok_r.toggle;
				end
			end
		end
	end

	// Payload byte counter and overlength flag
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r  <= 11'd0;
			long_r <= 1'b0;
		end else if (state_r == URH_IDLE) begin
			cnt_r  <= 11'd0;
			long_r <= 1'b0;
		end else if (state_r == URH_PAY && rx_valid) begin
			if (cnt_r < `URH_MAX_PAYLOAD) begin
				cnt_r <= cnt_r + 11'd1;
			end else begin
				long_r <= 1'b1;
			end
		end
	end

	// Shared pool: next record follows the last one, any endpoint
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			base_r      <= '0;
			last_base_r <= '0;
			last_cnt_r  <= 11'd0;
		end else if (rec_end) begin
			base_r      <= base_r + AW'(total);
			last_base_r <= base_r;
			last_cnt_r  <= total;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Buffer write port

	// Chooses the record offset and byte for each write
	always_comb begin
		mem_we  = 1'b0;
		mem_off = 11'd0;
		mem_wd  = 8'h00;
		case (state_r)
			URH_PAY: begin
				if (rx_valid && cnt_r < `URH_MAX_PAYLOAD) begin
					mem_we  = 1'b1;
					mem_off = `URH_HDR_LEN + cnt_r;
					mem_wd  = rx_byte;
				end
			end
			URH_SER, URH_DMA: begin
				// header at offsets 0 to 7
				mem_we  = 1'b1;
				mem_off = {8'h00, idx_r};
				case (idx_r)
					// toggle bit, endpoint with bit 4 zero
					`URH_OFF_STAT:   mem_wd = {crc_r, tok_r.toggle, badtog_r, 1'b0, tok_r.ep};
					`URH_OFF_PID:    mem_wd = {4'h0, tok_r.pid};
					`URH_OFF_TADDR:  mem_wd = {1'b0, tok_r.addr};
					`URH_OFF_RSVD:   mem_wd = 8'h00;
					`URH_OFF_FRM_LO: mem_wd = tok_r.frame[7:0];
					`URH_OFF_FRM_HI: mem_wd = {tok_r.frame[15:11], tok_r.frame[10:8]};
					`URH_OFF_CNT_LO: mem_wd = total[7:0];
					default:         mem_wd = {5'h00, total[10:8]};
				endcase
			end
			default: mem_we = 1'b0;
		endcase
	end

	assign mem_wa = base_r + AW'(mem_off);

	urh_rec_mem #(
		.AW (AW),
		.DW (8)
	) u_mem (
		.clk (clk),
		.we  (mem_we),
		.wa  (mem_wa),
		.wd  (mem_wd),
		.ra  (ptr_nxt),
		.rd  (mem_q)
	);

	////////////////////////////////////////////////////////////////////////
	// Register port and interrupt

	// Events of the finished record
	always_comb begin
		ev_set = 4'h0;
		if (rec_end) begin
			ev_set[`URH_EV_DONE] = 1'b1;
			ev_set[`URH_EV_CRC]  = crc_r;
			ev_set[`URH_EV_LONG] = long_r;
			ev_set[`URH_EV_TOG]  = badtog_r;
		end
		ev_clr = (reg_wr && reg_addr == `URH_REG_INT_CLR) ? reg_wdata[3:0] : 4'h0;
		st_nxt = (st_r & ~ev_clr) | ev_set;
	end

	// Read pointer: written by software, steps after each data read
	always_comb begin
		ptr_nxt = ptr_r;
		if (reg_wr && reg_addr == `URH_REG_PTR_LO) begin
			ptr_nxt = {ptr_r[AW-1:8], reg_wdata};
		end else if (reg_wr && reg_addr == `URH_REG_PTR_HI) begin
			ptr_nxt = {reg_wdata[AW-9:0], ptr_r[7:0]};
		end else if (reg_rd && reg_addr == `URH_REG_MEM_DATA) begin
			ptr_nxt = ptr_r + AW'(1);
		end
	end

	// Writable registers and sticky status; set wins over clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			faddr_r <= `URH_FADDR_RST;
			en_r    <= `URH_INT_EN_RST;
			st_r    <= 4'h0;
			ptr_r   <= '0;
		end else begin
			st_r  <= st_nxt;
			ptr_r <= ptr_nxt;
			if (reg_wr && reg_addr == `URH_REG_FADDR) begin
				faddr_r <= reg_wdata[6:0];
			end
			if (reg_wr && reg_addr == `URH_REG_INT_EN) begin
				en_r <= reg_wdata[3:0];
			end
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (!reg_rd) begin
			reg_rdata <= 8'h00;
		end else if (reg_addr == `URH_REG_FADDR) begin
			reg_rdata <= {1'b0, faddr_r};
		end else if (reg_addr == `URH_REG_STATUS) begin
			reg_rdata <= {4'h0, st_r};
		end else if (reg_addr == `URH_REG_INT_EN) begin
			reg_rdata <= {4'h0, en_r};
		end else if (reg_addr == `URH_REG_PTR_LO) begin
			reg_rdata <= ptr_r[7:0];
		end else if (reg_addr == `URH_REG_PTR_HI) begin
			reg_rdata <= 8'(ptr_r[AW-1:8]);
		end else if (reg_addr == `URH_REG_MEM_DATA) begin
			reg_rdata <= mem_q;
		end else if (reg_addr == `URH_REG_BASE_LO) begin
			reg_rdata <= last_base_r[7:0];
		end else if (reg_addr == `URH_REG_BASE_HI) begin
			reg_rdata <= 8'(last_base_r[AW-1:8]);
		end else if (reg_addr == `URH_REG_CNT_LO) begin
			reg_rdata <= last_cnt_r[7:0];
		end else if (reg_addr == `URH_REG_CNT_HI) begin
			reg_rdata <= {5'h00, last_cnt_r[10:8]};
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Level interrupt from enabled status bits
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(st_r & en_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_start_match: assert property (@(posedge clk) disable iff (!arst_n)
		(state_r == URH_IDLE) ##1 (state_r == URH_PAY) |-> $past(hit))
		else $error("record started without address match");

	a_payload_off: assert property (@(posedge clk) disable iff (!arst_n)
		(mem_we && state_r == URH_PAY) |-> (mem_off == cnt_r + 11'd8))
		else $error("payload byte at wrong offset");

	a_ser_bytes: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(state_r == URH_SER) |-> (idx_r == 3'd0) ##1 (idx_r == 3'd1) ##1 (idx_r == 3'd2)
		##1 (idx_r == 3'd3) ##1 (idx_r == 3'd4) ##1 (idx_r == 3'd5) ##1 (state_r == URH_DMA))
		else $error("serial header bytes out of order");

	a_dma_bytes: assert property (@(posedge clk) disable iff (!arst_n)
		(mem_we && mem_off >= 11'd6 && mem_off <= 11'd7) |-> (state_r == URH_DMA))
		else $error("count bytes written outside DMA stage");

	a_count_val: assert property (@(posedge clk) disable iff (!arst_n)
		(state_r == URH_DMA && idx_r == 3'd6) |->
		(mem_wd == total[7:0]) ##1 (mem_wd == {5'h00, total[10:8]} && mem_off == 11'd7))
		else $error("byte count bytes wrong");

	a_toggle_flag: assert property (@(posedge clk) disable iff (!arst_n)
		(state_r == URH_PAY && rx_end) |=>
		(badtog_r == ($past(tok_r.toggle) == $past(prev_tog_r[tok_r.ep]))))
		else $error("repeat toggle flag wrong");

	a_status_byte: assert property (@(posedge clk) disable iff (!arst_n)
		(state_r == URH_SER && idx_r == 3'd0) |->
		(mem_wd[6] == tok_r.toggle && mem_wd[7] == crc_r && mem_wd[4] == 1'b0))
		else $error("status byte toggle or CRC bit wrong");

	a_crc_latch: assert property (@(posedge clk) disable iff (!arst_n)
		(state_r == URH_PAY && rx_end) |-> ##7 (mem_off == 11'd0 || crc_r == $past(rx_crc_bad, 7)))
		else $error("CRC flag not kept");

	a_frame_bytes: assert property (@(posedge clk) disable iff (!arst_n)
		(state_r == URH_SER && idx_r == 3'd5) |-> (mem_wd == tok_r.frame[15:8]))
		else $error("frame count byte wrong");

	a_max_len: assert property (@(posedge clk) disable iff (!arst_n)
		(cnt_r <= 11'd1280) && (!mem_we || mem_off < 11'd1288))
		else $error("record longer than 1288 bytes");

	a_irq_level: assert property (@(posedge clk) disable iff (!arst_n)
		##1 (irq == $past(|(st_r & en_r))))
		else $error("interrupt level wrong");

endmodule // urh_hdr_writer

// ### core/urh_pkg.sv
/*
 * Types of the receive packet header writer.
 * Assumes nothing of its surroundings.
 */
package urh_pkg;

	// Record writer states
	typedef enum logic [1:0] {
		URH_IDLE = 2'b00,
		URH_PAY  = 2'b01,
		URH_SER  = 2'b10,
		URH_DMA  = 2'b11
	} urh_state_t;

	// Token seen by the serial engine at the start of a packet
	typedef struct packed {
		logic [6:0]  addr;
		logic [3:0]  ep;
		logic [3:0]  pid;
		logic        toggle;
		logic [15:0] frame;
	} urh_tok_t;

endpackage

// ### core/urh_rec_mem.sv
/*
 * Packet buffer memory: one write port, one read port with registered data.
 * Assumes a single clock; no reset on the array.
 */
`timescale 1ns/1ps

module urh_rec_mem #(
	parameter int AW = 12,
	parameter int DW = 8
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] wa,
	input  wire logic [DW-1:0] wd,
	input  wire logic [AW-1:0] ra,
	output      logic [DW-1:0] rd
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Write port
	always_ff @(posedge clk) begin
		if (we) begin
			mem[wa] <= wd;
		end
	end

	// Registered read; a same-cycle write to ra returns old data
	always_ff @(posedge clk) begin
		rd <= mem[ra];
	end

endmodule // urh_rec_mem

// ### tb/urh_hdr_writer_tb.sv
/*
 * Self-checking bench of the receive header writer, random packets and corners.
 * Assumes the host model beside it and the register port of the design.
 */
`timescale 1ns/1ps
`include "urh_consts.svh"

module urh_hdr_writer_tb import urh_pkg::*; ;

	logic       clk;
	logic       arst_n;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       rx_start;
	logic       rx_valid;
	logic       rx_end;
	logic       rx_crc_bad;
	logic       irq;
	logic [7:0] rx_byte;
	urh_tok_t   rx_tok;
	int         mismatches;
	int         checks;
	logic [6:0] faddr;
	logic [11:0] base;
	logic       received_toggle_value [16];

	urh_hdr_writer #(.AW(12)) dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_start(rx_start), .rx_tok(rx_tok),
		.rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end), .rx_crc_bad(rx_crc_bad), .irq(irq));

	urh_host_model host_u (.clk(clk), .rx_start(rx_start), .rx_tok(rx_tok), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .rx_end(rx_end), .rx_crc_bad(rx_crc_bad));

	// Clock of 25 ns
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Expected header byte at offset i
	function automatic logic [7:0] hdr(input urh_tok_t t, input logic bad, input logic rep,
		input logic [10:0] c, input int i);
		case (i)
			0: hdr = {bad, t.toggle, rep, 1'b0, t.ep};
			1: hdr = {4'h0, t.pid};
			2: hdr = {1'b0, t.addr};
			4: hdr = t.frame[7:0];
			5: hdr = t.frame[15:8];
			6: hdr = c[7:0];
			7: hdr = {5'h00, c[10:8]};
			default: hdr = 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// One packet: send, then check status; if addressed also irq, record and clear
	task automatic pkt(input int n, input logic bad, input logic hit);
		urh_tok_t    t;
		logic [7:0]  d[$];
		logic [7:0]  v;
		logic [7:0]  en;
		logic [7:0]  st;
		logic        rep;
		logic [10:0] c;
		int          m;
		t = urh_tok_t'($urandom);
		t.addr = hit ? faddr : faddr ^ 7'h01;
		for (int i = 0; i < n; i++)
			d.push_back(8'($urandom));
		en = 8'($urandom) & 8'h0f;
		wr(`URH_REG_INT_EN, en);
		host_u.send(t, d, bad);
		rd(`URH_REG_STATUS, v);
		if (!hit) begin
			chk(v, 8'h00);
			return;
		end
		rep = (t.toggle == received_toggle_value[t.ep]);
		if (!bad)
			received_toggle_value[t.ep] = t.toggle;
		m = (n > 1280) ? 1280 : n;
		c = 11'(m + 8);
		st = {4'h0, rep, n > 1280, bad, 1'b1};
		chk(v, st);
		chk({7'h00, irq}, {7'h00, |(st & en)});
		rd(`URH_REG_BASE_LO, v);
		chk(v, base[7:0]);
		rd(`URH_REG_BASE_HI, v);
		chk(v, {4'h0, base[11:8]});
		rd(`URH_REG_CNT_LO, v);
		chk(v, c[7:0]);
		rd(`URH_REG_CNT_HI, v);
		chk(v, {5'h00, c[10:8]});
		wr(`URH_REG_PTR_LO, base[7:0]);
		wr(`URH_REG_PTR_HI, {4'h0, base[11:8]});
		for (int i = 0; i < m + 8; i++) begin
			rd(`URH_REG_MEM_DATA, v);
			if (i == 0)
				chk({4'h0, v[3:0]}, {4'h0, t.ep});
			if (i < 8)
				chk(v, hdr(t, bad, rep, c, i));
			else
				chk(v, d[i-8]);
		end
		base = base + 12'(c);
		wr(`URH_REG_INT_CLR, 8'h0f);
		rd(`URH_REG_STATUS, v);
		chk(v, 8'h00);
		chk({7'h00, irq}, 8'h00);
	endtask

	// Run cut short if it hangs
	initial begin
		#(25ns * 100000);
		mismatches++;
		wrap_up();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [7:0] v;
		arst_n    = 1'b0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		base      = 12'h000;
		foreach (received_toggle_value[i])
			received_toggle_value[i] = 1'b0;
		void'($urandom(82142));
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		rd(`URH_REG_FADDR, v);
		chk(v, 8'h00);
		rd(`URH_REG_INT_EN, v);
		chk(v, 8'h00);
		wr(8'hff, 8'h5a);
		wr(`URH_REG_PTR_HI, 8'hff);
		rd(`URH_REG_PTR_HI, v);
		chk(v, 8'h0f);
		rd(8'hff, v);
		chk(v, 8'h00);
		faddr = 7'($urandom);
		wr(`URH_REG_FADDR, {1'b0, faddr});
		rd(`URH_REG_FADDR, v);
		chk(v, {1'b0, faddr});
		// Corners: empty, bad crc, foreign address, largest, oversize
		pkt(0, 1'b0, 1'b1);
		pkt(1, 1'b1, 1'b1);
		pkt(5, 1'b0, 1'b0);
		pkt(1280, 1'b0, 1'b1);
		pkt(1281, 1'b0, 1'b1);
		repeat (14)
			pkt($urandom % 64, 1'($urandom), 1'b1);
		wrap_up();
	end

endmodule // urh_hdr_writer_tb

// ### tb/urh_host_model.sv
/*
 * Far-side model: the serial engine handing received packets to the writer.
 * Assumes the bench calls send once a packet and owns nothing of these lines.
 */
`timescale 1ns/1ps

module urh_host_model import urh_pkg::*; (
	input  wire logic clk,
	output logic      rx_start,
	output urh_tok_t  rx_tok,
	output logic      rx_valid,
	output logic [7:0] rx_byte,
	output logic      rx_end,
	output logic      rx_crc_bad
);

	// Quiet lines at time zero
	initial begin
		rx_start   = 1'b0;
		rx_tok     = '0;
		rx_valid   = 1'b0;
		rx_byte    = 8'h00;
		rx_end     = 1'b0;
		rx_crc_bad = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// token then ordered bytes
	task automatic send(input urh_tok_t t, input logic [7:0] d[$], input logic bad);
		@(posedge clk);
		rx_start <= 1'b1;
		rx_tok   <= t;
		foreach (d[i]) begin
			@(posedge clk);
			rx_start <= 1'b0;
			rx_tok   <= ~t;   // Token no longer valid
			rx_valid <= 1'b1;
			rx_byte  <= d[i];
		end
		@(posedge clk);
		rx_start   <= 1'b0;
		rx_tok     <= ~t;
		rx_valid   <= 1'b0;
		rx_byte    <= ~rx_byte;   // Released line shows inverse
		rx_end     <= 1'b1;
		rx_crc_bad <= bad;
		@(posedge clk);
		rx_end     <= 1'b0;
		rx_crc_bad <= ~bad;
		// Spacing before the next token
		repeat (9) @(posedge clk);
	endtask

endmodule // urh_host_model
